/* hdl/dbe_rw_access.sv */
// Debug read/write access engine with bus error, rewrite, cancel and reset handling.
//
// Chosen here: the Avalon-MM interface to the registers and the address map.
module dbe_rw_access (
  input wire logic clk,
  input wire logic reset,
  input wire logic sys_reset,
  input wire logic [dbe_pkg::AV_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [dbe_pkg::DATA_W-1:0] avs_writedata,
  output logic [dbe_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  output dbe_pkg::dbe_lb_req_t lb_req,
  input wire dbe_pkg::dbe_lb_rsp_t lb_rsp,
  output dbe_pkg::dbe_msg_t msg,
  output logic irq
);
  import dbe_pkg::*;

  typedef struct packed {
    dbe_state_t state;
    logic wait_q;
    logic [DATA_W-1:0] rdata_q;
    logic [RWA_W-1:0] rwa_q;
    logic [ADDR_W-1:0] rw_access_address_ctrl_q;
    logic addr_ok_q;
    logic [DATA_W-1:0] udi_q;
    logic dv_q;
    logic uerr_q;
    logic [ADDR_W-1:0] cur_addr_q;
    logic [CNT_W-1:0] cnt_q;
    logic abort_q;
    dbe_lb_req_t lb_q;
    dbe_msg_t msg_q;
    logic [IRQ_W-1:0] sts_q;
    logic [IRQ_W-1:0] en_q;
    logic irq_q;
  } dbe_regs_t;

  dbe_regs_t r_q;
  dbe_regs_t r_d;
  logic wr_acc;
  logic rd_acc;
  logic [IRQ_W-1:0] ev;
  logic [IRQ_W-1:0] clr;
  logic is_read;

  // Zero-extends a narrow field into a bus word.
  function automatic logic [DATA_W-1:0] widen(input logic [RWA_W-1:0] v);
    widen = {{(DATA_W-RWA_W){1'b0}}, v};
  endfunction : widen

  // Builds an error message with the given code.
  function automatic dbe_msg_t err_msg(input logic [4:0] code);
    err_msg = '{valid: 1'b1, transfer_code: TRANSFER_CODE_ERROR, ecode: code};
  endfunction : err_msg

  // The bus request stands through the one cycle that waitrequest is low, so writes and reads act there.
  assign wr_acc = avs_write && !r_q.wait_q;
  assign rd_acc = avs_read && !r_q.wait_q;
  assign is_read = r_q.rwa_q[RWA_READ];

  always_comb begin
    r_d = r_q;
    ev = '0;
    clr = '0;
    r_d.msg_q.valid = 1'b0;

    // Avalon handshake: one wait cycle, then a single cycle with waitrequest low.
    if (r_q.wait_q && (avs_read || avs_write)) begin
      r_d.wait_q = 1'b0;
      r_d.rdata_q = ZERO_WORD;
      if (avs_address == OFS_RWA) begin
        r_d.rdata_q = widen(r_q.rwa_q);
      end else if (avs_address == OFS_RW_ACCESS_ADDRESS_CTRL) begin
        r_d.rdata_q = r_q.rw_access_address_ctrl_q;
      end else if (avs_address == OFS_UDI) begin
        r_d.rdata_q = r_q.udi_q;
      end else if (avs_address == OFS_UDI_STS) begin
        r_d.rdata_q[UDI_DV] = r_q.dv_q;
        r_d.rdata_q[UDI_ERR] = r_q.uerr_q;
      end else if (avs_address == OFS_IRQ_STS) begin
        r_d.rdata_q[IRQ_W-1:0] = r_q.sts_q;
      end else if (avs_address == OFS_IRQ_EN) begin
        r_d.rdata_q[IRQ_W-1:0] = r_q.en_q;
      end
    end else begin
      r_d.wait_q = 1'b1;
    end

    // Register writes; a rewrite of the access register while busy also requests an abort.
    if (wr_acc) begin
      if (avs_address == OFS_RWA) begin
        r_d.rwa_q = avs_writedata[RWA_W-1:0];
        if (r_q.state != ST_IDLE) begin
          r_d.abort_q = 1'b1;
        end
      end else if (avs_address == OFS_RW_ACCESS_ADDRESS_CTRL) begin
        r_d.rw_access_address_ctrl_q = avs_writedata;
        r_d.addr_ok_q = 1'b1;
      end else if (avs_address == OFS_UDI) begin
        r_d.udi_q = avs_writedata;
        r_d.dv_q = 1'b1;
        r_d.uerr_q = 1'b0;
      end else if (avs_address == OFS_IRQ_CLR) begin
        clr = avs_writedata[IRQ_W-1:0];
      end else if (avs_address == OFS_IRQ_EN) begin
        r_d.en_q = avs_writedata[IRQ_W-1:0];
      end
    end
    // Reading the data word hands it to the tool, freeing the slot for the next read beat.
    if (rd_acc && avs_address == OFS_UDI && is_read) begin
      r_d.dv_q = 1'b0;
    end

    case (r_q.state)
      ST_IDLE: begin
        if (r_q.rwa_q[RWA_START]) begin
          if (sys_reset) begin
            r_d.rwa_q[RWA_START] = 1'b0;
            r_d.msg_q = err_msg(ECODE_RESET);
            ev[IRQ_ERRMSG] = 1'b1;
          end else if (!r_q.addr_ok_q) begin
            // No address programmed: treated as a bus address error.
            r_d.rwa_q[RWA_START] = 1'b0;
            r_d.msg_q = err_msg(ECODE_ADDR);
            ev[IRQ_ERRMSG] = 1'b1;
          end else begin
            r_d.cur_addr_q = r_q.rw_access_address_ctrl_q;
            r_d.cnt_q = r_q.rwa_q[RWA_CNT_LO +: CNT_W];
            r_d.abort_q = 1'b0;
            r_d.uerr_q = 1'b0;
            if (is_read) begin
              r_d.dv_q = 1'b0;
            end
            r_d.state = ST_WAIT;
          end
        end
      end
      ST_WAIT: begin
        // Waits for the tool to empty (read) or fill (write) the data word.
        if (sys_reset) begin
          r_d.rwa_q[RWA_START] = 1'b0;
          r_d.msg_q = err_msg(ECODE_RESET);
          ev[IRQ_ERRMSG] = 1'b1;
          r_d.state = ST_IDLE;
        end else if (r_q.abort_q || wr_acc && avs_address == OFS_RWA) begin
          r_d.abort_q = 1'b1;
          r_d.state = ST_RECOVER;
        end else if (is_read ? !r_q.dv_q : r_q.dv_q) begin
          r_d.lb_q = '{req: 1'b1, we: !is_read, addr: r_q.cur_addr_q, wdata: r_q.udi_q};
          r_d.state = ST_ISSUE;
        end
      end
      ST_ISSUE: begin
        if (sys_reset) begin
          // The pending bus cycle is dropped; reset also clears the on-chip bus.
          r_d.lb_q.req = 1'b0;
          r_d.rwa_q[RWA_START] = 1'b0;
          r_d.msg_q = err_msg(ECODE_RESET);
          ev[IRQ_ERRMSG] = 1'b1;
          r_d.state = ST_IDLE;
        end else if (lb_rsp.ack) begin
          r_d.lb_q.req = 1'b0;
          if (lb_rsp.addr_err || lb_rsp.data_err) begin
            r_d.rwa_q[RWA_START] = 1'b0;
            r_d.state = ST_IDLE;
            if (is_read && !lb_rsp.addr_err) begin
              r_d.uerr_q = 1'b1;
              r_d.dv_q = 1'b0;
              ev[IRQ_RDERR] = 1'b1;
            end else begin
              r_d.msg_q = err_msg(lb_rsp.addr_err ? ECODE_ADDR : ECODE_WR_DATA);
              ev[IRQ_ERRMSG] = 1'b1;
              if (is_read) begin
                r_d.uerr_q = 1'b1;
                r_d.dv_q = 1'b0;
              end
            end
          end else if (r_q.abort_q || wr_acc && avs_address == OFS_RWA) begin
            // Beat completed after a rewrite: its data is thrown away.
            r_d.abort_q = 1'b1;
            if (!is_read) begin
              r_d.dv_q = 1'b0;
            end
            r_d.state = ST_RECOVER;
          end else begin
            if (is_read) begin
              r_d.udi_q = lb_rsp.rdata;
              r_d.dv_q = 1'b1;
            end else begin
              r_d.dv_q = 1'b0;
            end
            r_d.cur_addr_q = r_q.cur_addr_q + BEAT_BYTES;
            if (r_q.cnt_q == '0) begin
              r_d.rwa_q[RWA_START] = 1'b0;
              r_d.msg_q = '{valid: 1'b1, transfer_code: TRANSFER_CODE_READY, ecode: 5'h00};
              ev[IRQ_DONE] = 1'b1;
              r_d.state = ST_IDLE;
            end else begin
              r_d.cnt_q = r_q.cnt_q - 1'b1;
              r_d.state = ST_WAIT;
            end
          end
        end
      end
      ST_RECOVER: begin
        // One idle cycle lets the controller settle before the next access may begin.
        r_d.abort_q = 1'b0;
        r_d.state = ST_IDLE;
        if (!r_q.rwa_q[RWA_START]) begin
          r_d.msg_q = '{valid: 1'b1, transfer_code: TRANSFER_CODE_READY, ecode: 5'h00};
          ev[IRQ_DONE] = 1'b1;
        end
      end
      default: begin
        r_d.state = ST_IDLE;
      end
    endcase

    // Sticky status: a new event wins over a clear in the same cycle.
    r_d.sts_q = (r_q.sts_q & ~clr) | ev;
    r_d.irq_q = |(r_d.sts_q & r_d.en_q);
  end

  // All state registers; the synchronous reset returns every field to its idle value.
  always_ff @(posedge clk) begin
    if (reset) begin
      r_q <= '0;
      r_q.state <= ST_IDLE;
      r_q.wait_q <= 1'b1;
      r_q.rwa_q <= RWA_RESET;
    end else begin
      r_q <= r_d;
    end
  end

  // Outputs come straight from the state register.
  assign avs_readdata = r_q.rdata_q;
  assign avs_waitrequest = r_q.wait_q;
  assign lb_req = r_q.lb_q;
  assign msg = r_q.msg_q;
  assign irq = r_q.irq_q;
endmodule : dbe_rw_access

/* hdl/dbe_pkg.sv */
// Package with constants and carrier types of the debug access error-handling engine.
// Overview of operation
// - Bus data errors arrive with the transfer acknowledge that ends the access.
// - Read ending in bus error sets the error bit and clears data valid.
// - Write ending in bus data error sends transfer code 8 message, error code 00011.
// - Start without valid address yields an address error reported as usual.
// - Access register rewrite mid-block stops at next beat boundary, data discarded.
// - A newly programmed access starts only after the controller has recovered.
// - Clearing the start bit mid-block ends it and sends a ready message.
// - System reset during an access ends it, clears start, sends error message.
// - Start requested during system reset is refused, start cleared, error message.
// - Address errors and write data errors send messages with distinct codes.
package dbe_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 32;
  localparam int AV_ADDR_W = 5;
  localparam int CNT_W = 8;
  localparam int IRQ_W = 3;
  // Register byte offsets on the Avalon slave.
  localparam logic [AV_ADDR_W-1:0] OFS_RWA = 5'h00;
  localparam logic [AV_ADDR_W-1:0] OFS_RW_ACCESS_ADDRESS_CTRL = 5'h04;
  localparam logic [AV_ADDR_W-1:0] OFS_UDI = 5'h08;
  localparam logic [AV_ADDR_W-1:0] OFS_UDI_STS = 5'h0C;
  localparam logic [AV_ADDR_W-1:0] OFS_IRQ_STS = 5'h10;
  localparam logic [AV_ADDR_W-1:0] OFS_IRQ_CLR = 5'h14;
  localparam logic [AV_ADDR_W-1:0] OFS_IRQ_EN = 5'h18;
  // Access register fields.
  localparam int RWA_START = 0;
  localparam int RWA_READ = 1;
  localparam int RWA_CNT_LO = 8;
  localparam int RWA_W = 16;
  localparam logic [RWA_W-1:0] RWA_RESET = 16'h0000;
  // Status bits of the data register and interrupt sources.
  localparam int UDI_DV = 0;
  localparam int UDI_ERR = 1;
  localparam int IRQ_RDERR = 0;
  localparam int IRQ_ERRMSG = 1;
  localparam int IRQ_DONE = 2;
  // Message codes.
  localparam logic [5:0] TRANSFER_CODE_ERROR = 6'h08;
  localparam logic [5:0] TRANSFER_CODE_READY = 6'h07;
  localparam logic [4:0] ECODE_WR_DATA = 5'h03;
  localparam logic [4:0] ECODE_ADDR = 5'h01;
  localparam logic [4:0] ECODE_RESET = 5'h02;
  localparam logic [ADDR_W-1:0] BEAT_BYTES = 32'h0000_0004;
  localparam logic [DATA_W-1:0] ZERO_WORD = 32'h0000_0000;

  typedef enum {ST_IDLE, ST_WAIT, ST_ISSUE, ST_RECOVER} dbe_state_t;

  typedef struct packed {
    logic valid;
    logic [5:0] transfer_code;
    logic [4:0] ecode;
  } dbe_msg_t;

  typedef struct packed {
    logic req;
    logic we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } dbe_lb_req_t;

  typedef struct packed {
    logic ack;
    logic data_err;
    logic addr_err;
    logic [DATA_W-1:0] rdata;
  } dbe_lb_rsp_t;
endpackage : dbe_pkg

/* verif/dbe_rw_access_asserts.sv */
// Port checker of the debug access engine.
module dbe_rw_access_asserts import dbe_pkg::*; (
  input wire logic clk,
  input wire logic reset,
  input wire logic sys_reset,
  input wire logic avs_waitrequest,
  input wire dbe_pkg::dbe_lb_req_t lb_req,
  input wire dbe_pkg::dbe_lb_rsp_t lb_rsp,
  input wire dbe_pkg::dbe_msg_t msg
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic ok_ack;
  // An acknowledged beat that no system reset disturbs.
  assign ok_ack = lb_req.req && lb_rsp.ack && !sys_reset;
  AST_WR_ERR: assert property (ok_ack && lb_req.we && lb_rsp.data_err && !lb_rsp.addr_err |=>
    msg.valid && msg.transfer_code == TRANSFER_CODE_ERROR && msg.ecode == ECODE_WR_DATA) else $error("write error msg");
  AST_ADDR_ERR: assert property (ok_ack && lb_rsp.addr_err |=>
    msg.valid && msg.transfer_code == TRANSFER_CODE_ERROR && msg.ecode == ECODE_ADDR) else $error("address error msg");
  AST_RD_ERR_QUIET: assert property (ok_ack && !lb_req.we && lb_rsp.data_err && !lb_rsp.addr_err |=>
    !msg.valid) else $error("read data error sent a message");
  AST_ACK_ENDS: assert property (lb_req.req && lb_rsp.ack |=> !lb_req.req) else $error("request after ack");
  AST_REQ_HOLD: assert property (lb_req.req && !lb_rsp.ack && !sys_reset |=>
    lb_req.req && $stable(lb_req.addr)) else $error("beat dropped before ack");
  AST_SYSRST: assert property (lb_req.req && sys_reset |-> ##[1:2]
    (msg.valid && msg.ecode == ECODE_RESET)) else $error("no reset error msg");
  AST_NO_START: assert property (sys_reset |=> !lb_req.req) else $error("bus request in system reset");
  AST_WAIT_PULSE: assert property (!avs_waitrequest |=> avs_waitrequest) else $error("waitrequest low too long");
  // Main scenarios of the run.
  cover property (msg.valid && msg.transfer_code == TRANSFER_CODE_READY);
  cover property (ok_ack && lb_req.we && lb_rsp.data_err);
  cover property (lb_req.req && sys_reset);
endmodule : dbe_rw_access_asserts

bind dbe_rw_access dbe_rw_access_asserts u_chk (.clk(clk), .reset(reset), .sys_reset(sys_reset),
  .avs_waitrequest(avs_waitrequest), .lb_req(lb_req), .lb_rsp(lb_rsp), .msg(msg));

/* verif/dbe_bus_model.sv */
// Behavioural on-chip bus slave facing the access engine.
module dbe_bus_model import dbe_pkg::*; (
  input wire logic clk,
  input wire logic reset,
  input wire dbe_pkg::dbe_lb_req_t lb_req,
  output dbe_pkg::dbe_lb_rsp_t lb_rsp,
  input wire logic [1:0] err_mode,
  input wire logic [3:0] delay
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q;
  // Ack delay+1 cycles after the request appears; outside the ack the data lines churn so stale data is never mistaken for good.
  always_ff @(posedge clk) begin
    lb_rsp.ack <= 1'b0;
    lb_rsp.data_err <= 1'b0;
    lb_rsp.addr_err <= 1'b0;
    lb_rsp.rdata <= reset ? 32'h0F0F_0F0F : ~lb_rsp.rdata;
    cnt_q <= 4'h0;
    if (!reset && lb_req.req && !lb_rsp.ack) begin
      cnt_q <= cnt_q + 4'h1;
      if (cnt_q == delay) begin
        lb_rsp.ack <= 1'b1;
        lb_rsp.data_err <= err_mode[0];
        lb_rsp.addr_err <= err_mode[1];
        lb_rsp.rdata <= lb_req.addr ^ 32'h5A5A_0000;
      end
    end
  end
endmodule : dbe_bus_model

/* verif/test_dbe_rw_access.sv */
// Self-checking bench of the debug access engine.
module test_dbe_rw_access import dbe_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic sys_reset = 1'b0;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata, q, a, d;
  logic avs_waitrequest, irq;
  dbe_lb_req_t lb_req;
  dbe_lb_rsp_t lb_rsp;
  dbe_msg_t msg, last_msg;
  logic [1:0] err_mode = 2'h0;
  logic [3:0] delay = 4'h0;
  int miscompares = 0;
  int checked = 0;
  int msgs = 0;
  int n0 = 0;

  initial forever #5 clk = ~clk;
  dbe_rw_access dut (.clk(clk), .reset(reset), .sys_reset(sys_reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .lb_req(lb_req), .lb_rsp(lb_rsp), .msg(msg), .irq(irq));
  dbe_bus_model u_bus (.clk(clk), .reset(reset), .lb_req(lb_req), .lb_rsp(lb_rsp), .err_mode(err_mode),
    .delay(delay));

  // Count message pulses so a scenario can wait for the next one.
  always @(posedge clk) if (msg.valid === 1'b1) begin
    msgs <= msgs + 1;
    last_msg <= msg;
  end

  function automatic logic [31:0] exp_rd(input logic [31:0] ad);
    return ad ^ 32'h5A5A_0000;
  endfunction : exp_rd

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // One Avalon access held until waitrequest is sampled low; one idle edge follows.
  task automatic av(input logic w, input logic [4:0] ad, input logic [31:0] wd);
    avs_address <= ad;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= wd;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask : av

  task automatic go(input logic [31:0] ad, input logic [31:0] rw_access_reg);
    av(1'b1, OFS_RW_ACCESS_ADDRESS_CTRL, ad);
    n0 = msgs;
    av(1'b1, OFS_RWA, rw_access_reg);
  endtask : go

  task automatic wait_msg(input logic [5:0] tc, input logic [4:0] ec, input logic use_ec);
    while (msgs == n0) @(posedge clk);
    chk("msg code", last_msg.transfer_code, tc);
    if (use_ec) chk("error code", last_msg.ecode, ec);
  endtask : wait_msg

  task automatic stop_test;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : stop_test

  // A hang counts as a mismatch; the run needs far fewer cycles than this.
  initial begin
    #300000;
    miscompares++;
    stop_test();
  end

  initial begin
    void'($urandom(32'h0000_e452));
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    av(1'b0, OFS_UDI_STS, 0);
    chk("status at reset", q, 0);
    av(1'b0, 5'h1C, 0);
    chk("unmapped read", q, 0);
    av(1'b1, OFS_IRQ_EN, 32'h0000_0007);
    n0 = msgs;
    av(1'b1, OFS_RWA, 32'h0000_0003);
    wait_msg(TRANSFER_CODE_ERROR, ECODE_ADDR, 1'b1);
    av(1'b0, OFS_RWA, 0);
    chk("start bit", q[0], 0);
    // Drop the sticky error-message bit so the ready interrupt below is really tested.
    av(1'b1, OFS_IRQ_CLR, 32'h0000_0007);
    $display("test no_address done");
    repeat (3) begin
      a = $urandom & 32'hFFFF_FFFC;
      delay <= 4'($urandom);
      go(a, 32'h0000_0003);
      wait_msg(TRANSFER_CODE_READY, 5'h00, 1'b0);
      chk("irq on ready", irq, 1);
      av(1'b0, OFS_UDI, 0);
      chk("read data", q, exp_rd(a));
      av(1'b1, OFS_IRQ_CLR, 32'h0000_0007);
      av(1'b0, OFS_IRQ_STS, 0);
      chk("irq cleared", {q[2:0], irq}, 0);
    end
    $display("test random_reads done");
    err_mode <= 2'h1;
    av(1'b1, OFS_IRQ_EN, 32'h0000_0001);
    go(a, 32'h0000_0003);
    while (irq !== 1'b1) @(posedge clk);
    av(1'b0, OFS_UDI_STS, 0);
    chk("read error status", q, 32'h0000_0002);
    chk("read error quiet", msgs, n0);
    av(1'b1, OFS_IRQ_EN, 0);
    av(1'b0, OFS_IRQ_STS, 0);
    chk("masked irq", {q[2:0], irq}, 2);
    av(1'b1, OFS_IRQ_CLR, 32'h0000_0001);
    av(1'b1, OFS_IRQ_EN, 32'h0000_0007);
    $display("test read_error done");
    av(1'b1, OFS_UDI, $urandom);
    go(a, 32'h0000_0001);
    wait_msg(TRANSFER_CODE_ERROR, ECODE_WR_DATA, 1'b1);
    err_mode <= 2'h2;
    go(a, 32'h0000_0003);
    wait_msg(TRANSFER_CODE_ERROR, ECODE_ADDR, 1'b1);
    err_mode <= 2'h0;
    $display("test bus_errors done");
    delay <= 4'h8;
    av(1'b0, OFS_UDI, 0);
    d = q;
    go(a, 32'h0000_0303);
    av(1'b1, OFS_RWA, 0);
    wait_msg(TRANSFER_CODE_READY, 5'h00, 1'b0);
    av(1'b0, OFS_UDI, 0);
    chk("discarded data", q, d);
    go(a, 32'h0000_0303);
    av(1'b1, OFS_RWA, 32'h0000_0003);
    repeat (40) @(posedge clk);
    av(1'b0, OFS_UDI, 0);
    chk("new access data", q, exp_rd(a));
    $display("test rewrite done");
    delay <= 4'hC;
    go(a, 32'h0000_0303);
    sys_reset <= 1'b1;
    repeat (2) @(posedge clk);
    sys_reset <= 1'b0;
    wait_msg(TRANSFER_CODE_ERROR, ECODE_RESET, 1'b1);
    av(1'b0, OFS_RWA, 0);
    chk("start after reset", q[0], 0);
    sys_reset <= 1'b1;
    go(a, 32'h0000_0003);
    wait_msg(TRANSFER_CODE_ERROR, ECODE_RESET, 1'b1);
    av(1'b0, OFS_RWA, 0);
    chk("start refused", q[0], 0);
    sys_reset <= 1'b0;
    $display("test system_reset done");
    stop_test();
  end
endmodule : test_dbe_rw_access
